/* File: design/srap_port.v */
// Serial register access port: synchronised four-wire frame engine and the register file behind it
`include "srap_consts.vh"

// Contract
// [R01] Host keeps chip_select_n low throughout an access; only then are bits counted.
// [R02] Serial input sampled on serial clock rising edges; any slow clock rate works.
// [R03] A single access is exactly 24 bits: operation flag, address, data byte.
// [R04] Every field travels most significant bit first.
// [R05] Multi-byte registers are little-endian, low byte at the lowest address.
// [R06] First bit one means read, zero means write.
// [R07] Next fifteen bits carry the register address.
// [R08] A write stores the last eight input bits into the addressed register.
// [R09] A read ignores the last eight inputs and shifts the register out instead.
// [R10] Output stays undriven for writes and during the header of reads.
// [R11] Further bytes keep transferring while chip select stays low.
// [R12] Each further byte steps the address, up by default, down when selected.
// [R13] With address hold set the address stays fixed between bytes.
// [R14] Host makes no register access while calibration runs.
// [R15] Host leaves unmapped, reserved addresses unmodified.
// [R16] Fine gain trims are never changed by calibration.
// [R17] Each of eight cores has its own offset trim, per input where shared.
// [R18] One full-scale adjustment applies to all inputs together.
// [R19] Host does not write offset trims while offset calibration owns them.
// [R20] Chip select rising mid-byte discards the partial transfer and restarts counting.
module srap_port #(
  parameter [15:0] MAKER_ID     = 16'h5a5a,
  parameter [7:0]  TRIM_DEFAULT = 8'h00
) (
  input  wire         mclk,
  input  wire         reset,
  input  wire         chip_select_n,
  input  wire         serial_clock,
  input  wire         serial_in,
  output wire         serial_out,
  output wire         serial_out_oe_n,
  input  wire [7:0]   sync_capture_position,
  input  wire [7:0]   oscillator_cal_state,
  input  wire [7:0]   calibration_state,
  input  wire         cal_offset_we,
  input  wire [3:0]   cal_offset_sel,
  input  wire [7:0]   cal_offset_data,
  output wire [127:0] core_offset_trim,
  output wire [63:0]  core_fine_gain_trim,
  output wire [15:0]  full_scale_adjust,
  output wire         offset_cal_enable,
  output wire         background_cal_select
);

  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_HDR  = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  // Address of each stored byte; read-only locations are not stored
  function [`SRAP_ADDR_W-1:0] idx_addr;
    input integer i;
    integer off;
    begin
      off = 0;
      if (i >= `SRAP_GAIN_BASE) begin
        off      = i - `SRAP_GAIN_BASE;
        idx_addr = `SRAP_A_GAIN_FIRST + off[`SRAP_ADDR_W-1:0];
      end else if (i >= `SRAP_OFS_BASE) begin
        off      = i - `SRAP_OFS_BASE;
        idx_addr = `SRAP_A_OFS_FIRST + off[`SRAP_ADDR_W-1:0];
      end else begin
        case (i)
          0:  idx_addr = `SRAP_A_CFG_A;
          1:  idx_addr = `SRAP_A_DEV_CFG;
          2:  idx_addr = `SRAP_A_USR_CFG;
          3:  idx_addr = `SRAP_A_CLK0;
          4:  idx_addr = `SRAP_A_CLK1;
          5:  idx_addr = `SRAP_A_CLK2;
          6:  idx_addr = `SRAP_A_FS_LO;
          7:  idx_addr = `SRAP_A_FS_HI;
          8:  idx_addr = `SRAP_A_LP1;
          9:  idx_addr = `SRAP_A_TMSTP;
          10: idx_addr = `SRAP_A_PLLREFO;
          11: idx_addr = `SRAP_A_FBDIV_VP;
          12: idx_addr = `SRAP_A_FBDIV_N;
          13: idx_addr = `SRAP_A_OSC_CTRL;
          14: idx_addr = `SRAP_A_SERIALIZER_PREEMPHASIS;
          15: idx_addr = `SRAP_A_TRIGOUT;
          16: idx_addr = `SRAP_A_PLL_OVR;
          17: idx_addr = `SRAP_A_OSC_TRIM;
          18: idx_addr = `SRAP_A_PLL_RST;
          19: idx_addr = `SRAP_A_OSC_CAL;
          20: idx_addr = `SRAP_A_CAL_EN;
          21: idx_addr = `SRAP_A_CALIBRATION_CONFIG_ZERO;
          22: idx_addr = `SRAP_A_CALIBRATION_CONFIG_ONE;
          23: idx_addr = `SRAP_A_CALIBRATION_AVERAGING;
          24: idx_addr = `SRAP_A_CAL_PIN;
          25: idx_addr = `SRAP_A_CAL_TRIG;
          26: idx_addr = `SRAP_A_LOW_POWER_BACKGROUND_CAL;
          27: idx_addr = `SRAP_A_GAIN_DAC;
          28: idx_addr = `SRAP_A_BANDGAP;
          29: idx_addr = `SRAP_A_TERM_A;
          30: idx_addr = `SRAP_A_TERM_B;
          31: idx_addr = `SRAP_A_TERM_C;
          32: idx_addr = `SRAP_A_TERM_D;
          33: idx_addr = `SRAP_A_SRC_DLY;
          34: idx_addr = `SRAP_A_SEL_DLY;
          35: idx_addr = `SRAP_A_DITHER;
          36: idx_addr = `SRAP_A_LOWBIT;
          37: idx_addr = `SRAP_A_LINK_EN;
          default: idx_addr = `SRAP_A_LINK_MODE;
        endcase
      end
    end
  endfunction

  // Reset value of each stored byte; trims without a stated value take TRIM_DEFAULT
  function [7:0] idx_reset;
    input integer i;
    begin
      if (i >= `SRAP_OFS_BASE)
        idx_reset = TRIM_DEFAULT;
      else begin
        case (i)
          0:  idx_reset = `SRAP_R_CFG_A;
          3:  idx_reset = `SRAP_R_CLK0;
          5:  idx_reset = `SRAP_R_CLK2;
          6:  idx_reset = `SRAP_R_FS_LO;
          7:  idx_reset = `SRAP_R_FS_HI;
          8:  idx_reset = `SRAP_R_LP1;
          10: idx_reset = `SRAP_R_PLLREFO;
          12: idx_reset = `SRAP_R_FBDIV_N;
          13: idx_reset = `SRAP_R_OSC_CTRL;
          19: idx_reset = `SRAP_R_OSC_CAL;
          20: idx_reset = `SRAP_R_CAL_EN;
          21: idx_reset = `SRAP_R_CALIBRATION_CONFIG_ZERO;
          22: idx_reset = `SRAP_R_CALIBRATION_CONFIG_ONE;
          23: idx_reset = `SRAP_R_CALIBRATION_AVERAGING;
          25: idx_reset = `SRAP_R_CAL_TRIG;
          26: idx_reset = `SRAP_R_LOW_POWER_BACKGROUND_CAL;
          37: idx_reset = `SRAP_R_LINK_EN;
          17, 27, 28, 29, 30, 31, 32, 33, 34, 35: idx_reset = TRIM_DEFAULT;
          default: idx_reset = `SRAP_R_ZERO;
        endcase
      end
    end
  endfunction

  // Pin synchronisers; stage one feeds stage two only
  reg        cs_n_s1_reg;
  reg        cs_n_s2_reg;
  reg        sclk_s1_reg;
  reg        sclk_s2_reg;
  reg        sclk_s3_reg;
  reg        sdi_s1_reg;
  reg        sdi_s2_reg;

  reg [7:0]  mem [0:`SRAP_NUM_REGS-1];

  reg [2:0]  state_reg;
  reg [4:0]  hdr_cnt_reg;
  reg [2:0]  bit_cnt_reg;
  reg [14:0] hdr_shift_reg;
  reg [6:0]  data_shift_reg;
  reg        read_op_reg;
  reg [`SRAP_ADDR_W-1:0] addr_reg;
  reg        fetch_reg;
  reg [7:0]  tx_shift_reg;
  reg        sdo_reg;
  reg        sdo_oe_n_reg;
  reg        wr_pulse_reg;
  reg [5:0]  wr_idx_reg;
  reg [7:0]  wr_data_reg;

  wire       sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  wire       sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  wire       address_direction    = mem[0][`SRAP_ADDRESS_DIRECTION_BIT];
  wire       addr_hold = mem[2][`SRAP_HOLD_BIT];

  // Lookup of the current address in the stored map
  reg        hit;
  reg [5:0]  hit_idx;
  integer    k;
  always @* begin
    hit = 1'b0;
    hit_idx = 6'h00;
    for (k = 0; k < `SRAP_NUM_REGS; k = k + 1) begin
      if (idx_addr(k) == addr_reg) begin
        hit = 1'b1;
        hit_idx = k[5:0];
      end
    end
  end

  // Read data: stored bytes, read-only status, zero for unmapped addresses
  reg [7:0]  rd_byte;
  always @* begin
    if (addr_reg == `SRAP_A_MAKER_LO) begin
      rd_byte = MAKER_ID[7:0]; // [R05]
    end else if (addr_reg == `SRAP_A_MAKER_HI) begin
      rd_byte = MAKER_ID[15:8];
    end else if (addr_reg == `SRAP_A_SYNC_POS) begin
      rd_byte = sync_capture_position;
    end else if (addr_reg == `SRAP_A_OSC_STATE) begin
      rd_byte = oscillator_cal_state;
    end else if (addr_reg == `SRAP_A_CAL_STATE) begin
      rd_byte = calibration_state;
    end else if (hit) begin
      rd_byte = mem[hit_idx];
    end else begin
      rd_byte = `SRAP_R_ZERO;
    end
  end

  // Next address after a byte; holding wins over either direction
  reg [`SRAP_ADDR_W-1:0] addr_step;
  always @* begin
    if (addr_hold)
      addr_step = addr_reg; // [R13]
    else if (address_direction)
      addr_step = addr_reg + 15'h0001; // [R12]
    else
      addr_step = addr_reg - 15'h0001; // [R12]
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      cs_n_s1_reg <= 1'b1;
      cs_n_s2_reg <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      sdi_s1_reg  <= 1'b0;
      sdi_s2_reg  <= 1'b0;
    end else begin
      cs_n_s1_reg <= chip_select_n;
      cs_n_s2_reg <= cs_n_s1_reg;
      sclk_s1_reg <= serial_clock;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      sdi_s1_reg  <= serial_in;
      sdi_s2_reg  <= sdi_s1_reg;
    end
  end

  // Frame engine; sclk and sdi share the same sync delay so they stay aligned
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg      <= ST_OFF;
      hdr_cnt_reg    <= 5'd0;
      bit_cnt_reg    <= 3'd0;
      hdr_shift_reg  <= 15'h0000;
      data_shift_reg <= 7'h00;
      read_op_reg    <= 1'b0;
      addr_reg       <= 15'h0000;
      fetch_reg      <= 1'b0;
      tx_shift_reg   <= 8'h00;
      sdo_reg        <= 1'b0;
      sdo_oe_n_reg   <= 1'b1;
      wr_pulse_reg   <= 1'b0;
      wr_idx_reg     <= 6'h00;
      wr_data_reg    <= 8'h00;
    end else begin
      wr_pulse_reg <= 1'b0;
      fetch_reg    <= 1'b0;
      if (fetch_reg)
        tx_shift_reg <= rd_byte; // [R09]
      if (cs_n_s2_reg) begin
        // Deselect drops any partial header or byte
        state_reg    <= ST_OFF; // [R20]
        hdr_cnt_reg  <= 5'd0; // [R20]
        bit_cnt_reg  <= 3'd0;
        sdo_oe_n_reg <= 1'b1; // [R01]
        sdo_reg      <= 1'b0;
      end else begin
        case (state_reg)
          ST_OFF: begin
            state_reg <= ST_HDR; // [R01]
          end
          ST_HDR: begin
            sdo_oe_n_reg <= 1'b1; // [R10]
            if (sclk_rise) begin // [R02]
              hdr_shift_reg <= {hdr_shift_reg[13:0], sdi_s2_reg}; // [R04]
              hdr_cnt_reg   <= hdr_cnt_reg + 5'd1;
              if (hdr_cnt_reg == `SRAP_HDR_LAST) begin
                read_op_reg <= hdr_shift_reg[14]; // [R06]
                addr_reg    <= {hdr_shift_reg[13:0], sdi_s2_reg}; // [R07]
                fetch_reg   <= hdr_shift_reg[14];
                bit_cnt_reg <= 3'd0;
                state_reg   <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (sclk_rise) begin
              data_shift_reg <= {data_shift_reg[5:0], sdi_s2_reg}; // [R04]
              bit_cnt_reg    <= bit_cnt_reg + 3'd1;
              if (bit_cnt_reg == `SRAP_BYTE_LAST) begin // [R03]
                // Unmapped and read-only addresses take no write
                wr_pulse_reg <= ~read_op_reg & hit; // [R08]
                wr_idx_reg   <= hit_idx;
                wr_data_reg  <= {data_shift_reg, sdi_s2_reg}; // [R08]
                addr_reg     <= addr_step; // [R11]
                fetch_reg    <= read_op_reg; // [R11]
                bit_cnt_reg  <= 3'd0;
              end
            end
            // Reads drive on falling edges so the host can sample on the next rise
            if (sclk_fall && read_op_reg) begin
              sdo_oe_n_reg <= 1'b0; // [R09]
              sdo_reg      <= tx_shift_reg[7]; // [R04]
              tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end else if (!read_op_reg) begin
              sdo_oe_n_reg <= 1'b1; // [R10]
            end
          end
          default: begin
            state_reg <= ST_OFF;
          end
        endcase
      end
    end
  end

  // Register file; a serial write beats a calibration write in the same cycle
  integer n;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (n = 0; n < `SRAP_NUM_REGS; n = n + 1)
        mem[n] <= idx_reset(n);
    end else if (wr_pulse_reg) begin
      mem[wr_idx_reg] <= wr_data_reg; // [R08]
    end else if (cal_offset_we && offset_cal_enable) begin
      // Only offset trims are reachable from calibration; gain trims have no such path
      mem[`SRAP_OFS_BASE + cal_offset_sel] <= cal_offset_data; // [R16]
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SRAP_NUM_OFS; g = g + 1) begin : g_trim
      assign core_offset_trim[g*16 +: 16] =
        {mem[`SRAP_OFS_BASE + 2*g + 1], mem[`SRAP_OFS_BASE + 2*g]}; // [R17]
      assign core_fine_gain_trim[g*8 +: 8] = mem[`SRAP_GAIN_BASE + g];
    end
  endgenerate

  assign full_scale_adjust     = {mem[7], mem[6]}; // [R18]
  assign offset_cal_enable     = mem[21][`SRAP_CALOS_BIT];
  assign background_cal_select = mem[21][`SRAP_CALBG_BIT];
  assign serial_out            = sdo_reg;
  assign serial_out_oe_n       = sdo_oe_n_reg; // [R10]

endmodule // srap_port

/* File: common/srap_consts.vh */
// Constants for the serial register access port: frame layout, register map, reset values and field positions
`ifndef SRAP_CONSTS_VH
`define SRAP_CONSTS_VH

`define SRAP_ADDR_W        15
`define SRAP_HDR_LAST      5'd15
`define SRAP_BYTE_LAST     3'd7
`define SRAP_NUM_REGS      63
`define SRAP_NUM_FLAT      39
`define SRAP_OFS_BASE      39
`define SRAP_GAIN_BASE     55
`define SRAP_NUM_OFS       8
`define SRAP_NUM_GAIN      8

`define SRAP_A_CFG_A       15'h0000
`define SRAP_A_DEV_CFG     15'h0002
`define SRAP_A_MAKER_LO    15'h000c
`define SRAP_A_MAKER_HI    15'h000d
`define SRAP_A_USR_CFG     15'h0010
`define SRAP_A_CLK0        15'h0029
`define SRAP_A_CLK1        15'h002a
`define SRAP_A_CLK2        15'h002b
`define SRAP_A_SYNC_POS    15'h002c
`define SRAP_A_FS_LO       15'h0030
`define SRAP_A_FS_HI       15'h0031
`define SRAP_A_LP1         15'h0037
`define SRAP_A_TMSTP       15'h003b
`define SRAP_A_PLLREFO     15'h003c
`define SRAP_A_FBDIV_VP    15'h003d
`define SRAP_A_FBDIV_N     15'h003e
`define SRAP_A_OSC_CTRL    15'h003f
`define SRAP_A_SERIALIZER_PREEMPHASIS      15'h0048
`define SRAP_A_TRIGOUT     15'h0057
`define SRAP_A_PLL_OVR     15'h0058
`define SRAP_A_OSC_TRIM    15'h0059
`define SRAP_A_PLL_RST     15'h005c
`define SRAP_A_OSC_CAL     15'h005d
`define SRAP_A_OSC_STATE   15'h005e
`define SRAP_A_CAL_EN      15'h0061
`define SRAP_A_CALIBRATION_CONFIG_ZERO    15'h0062
`define SRAP_A_CALIBRATION_CONFIG_ONE    15'h0065
`define SRAP_A_CALIBRATION_AVERAGING     15'h0068
`define SRAP_A_CAL_STATE   15'h006a
`define SRAP_A_CAL_PIN     15'h006b
`define SRAP_A_CAL_TRIG    15'h006c
`define SRAP_A_LOW_POWER_BACKGROUND_CAL      15'h006e
`define SRAP_A_GAIN_DAC    15'h007a
`define SRAP_A_BANDGAP     15'h007c
`define SRAP_A_TERM_A      15'h007e
`define SRAP_A_TERM_B      15'h007f
`define SRAP_A_TERM_C      15'h0080
`define SRAP_A_TERM_D      15'h0081
`define SRAP_A_SRC_DLY     15'h009a
`define SRAP_A_SEL_DLY     15'h009b
`define SRAP_A_DITHER      15'h009d
`define SRAP_A_LOWBIT      15'h0160
`define SRAP_A_LINK_EN     15'h0200
`define SRAP_A_LINK_MODE   15'h0201
`define SRAP_A_OFS_FIRST   15'h0330
`define SRAP_A_GAIN_FIRST  15'h0360

`define SRAP_R_CFG_A       8'h30
`define SRAP_R_CLK0        8'h80
`define SRAP_R_CLK2        8'h10
`define SRAP_R_FS_LO       8'h00
`define SRAP_R_FS_HI       8'ha0
`define SRAP_R_LP1         8'h4b
`define SRAP_R_PLLREFO     8'h01
`define SRAP_R_FBDIV_N     8'h20
`define SRAP_R_OSC_CTRL    8'h4f
`define SRAP_R_OSC_CAL     8'h40
`define SRAP_R_CAL_EN      8'h01
`define SRAP_R_CALIBRATION_CONFIG_ZERO    8'h01
`define SRAP_R_CALIBRATION_CONFIG_ONE    8'h01
`define SRAP_R_CALIBRATION_AVERAGING     8'h61
`define SRAP_R_CAL_TRIG    8'h01
`define SRAP_R_LOW_POWER_BACKGROUND_CAL      8'h88
`define SRAP_R_LINK_EN     8'h01
`define SRAP_R_ZERO        8'h00

`define SRAP_ADDRESS_DIRECTION_BIT    5
`define SRAP_HOLD_BIT      0
`define SRAP_CALOS_BIT     1
`define SRAP_CALBG_BIT     0

`endif

/* File: verification/srap_checker_assertions.sv */
// Concurrent checks on the serial register access port boundary
`include "srap_consts.vh"
module srap_checker (
  input logic         mclk,
  input logic         reset,
  input logic         chip_select_n,
  input logic         serial_clock,
  input logic         serial_in,
  input logic         serial_out,
  input logic         serial_out_oe_n,
  input logic         cal_offset_we,
  input logic [3:0]   cal_offset_sel,
  input logic [7:0]   cal_offset_data,
  input logic [127:0] core_offset_trim,
  input logic [63:0]  core_fine_gain_trim,
  input logic [15:0]  full_scale_adjust,
  input logic         offset_cal_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Count survives chip select rise so a late enable still sees its frame
  logic       sck_q, cs_q, rw_q;
  logic [7:0] rises;
  logic [3:0] sel_q;
  logic [7:0] dat_q;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
      rw_q  <= 1'b0;
      rises <= 8'h00;
      sel_q <= 4'h0;
      dat_q <= 8'h00;
    end else begin
      sck_q <= serial_clock;
      cs_q  <= chip_select_n;
      if (cal_offset_we) begin
        sel_q <= cal_offset_sel;
        dat_q <= cal_offset_data;
      end
      if (cs_q && !chip_select_n) begin
        rises <= 8'h00;
      end else if (serial_clock && !sck_q && !chip_select_n && rises != 8'hff) begin
        rises <= rises + 8'h01;
        if (rises == 8'h00) begin
          rw_q <= serial_in;
        end
      end
    end
  end
  oe_idle_a: assert property (chip_select_n [*6] |-> serial_out_oe_n)
    else $error("output driven while deselected");
  oe_header_a: assert property (!serial_out_oe_n |-> rises >= 8'h10 && rw_q)
    else $error("output driven outside read data");
  oe_stay_a: assert property (!serial_out_oe_n && !chip_select_n |=> !serial_out_oe_n)
    else $error("output released inside a read");
  out_hold_a: assert property (!serial_out_oe_n && serial_clock |=> $stable(serial_out))
    else $error("read bit moved while clock high");
  regs_idle_a: assert property (chip_select_n [*8] |-> $stable(full_scale_adjust) && $stable(core_fine_gain_trim))
    else $error("register output moved while idle");
  cal_store_a: assert property (cal_offset_we && offset_cal_enable && chip_select_n |=>
    ##[0:1] core_offset_trim[{sel_q, 3'b000} +: 8] == dat_q)
    else $error("offset trim not stored");
  cal_block_a: assert property (chip_select_n && !offset_cal_enable |=> $stable(core_offset_trim))
    else $error("offset trim moved without enable");
  reset_vals_a: assert property ($fell(reset) |-> full_scale_adjust == {`SRAP_R_FS_HI, `SRAP_R_FS_LO} &&
    serial_out_oe_n)
    else $error("wrong value after reset");
  cover property ($fell(serial_out_oe_n));
  cover property (cal_offset_we && offset_cal_enable);
  cover property (rises == 8'h20);
endmodule // srap_checker

/* File: verification/srap_host_model.sv */
// Host controller model driving the four-wire register port
module srap_host_model (
  input  wire logic mclk,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  wire sdo_pin = serial_out_oe_n ? 1'bz : serial_out;
  initial begin
    chip_select_n = 1'b1;
    serial_clock  = 1'b0;
    serial_in     = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Clock stands low between frames; each level lasts 4 mclk
  task automatic shift(input int n, input logic [31:0] v, output logic [31:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = v[i];
      wait_n(4);
      serial_clock = 1'b1;
      got = {got[30:0], sdo_pin};
      wait_n(4);
      serial_clock = 1'b0;
    end
  endtask
  // A nonzero tail leaves a partial unit behind to exercise the discard path
  task automatic frame(input logic rd, input logic [14:0] a, input int nb, input logic [63:0] wd,
                       input int tail, output logic [63:0] rdat);
    logic [31:0] g;
    rdat = '0;
    chip_select_n = 1'b0;
    wait_n(4);
    shift(16, {16'h0000, rd, a}, g);
    for (int k = 0; k < nb; k++) begin
      shift(8, {24'h000000, wd[8*k +: 8]}, g);
      rdat[8*k +: 8] = g[7:0];
    end
    if (tail > 0) shift(tail, wd[31:0], g);
    wait_n(4);
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    wait_n(6);
  endtask
endmodule // srap_host_model

/* File: verification/test_serial_register_access_port.sv */
// Self-checking bench for the serial register access port
`include "srap_consts.vh"
`define SRAP_CHK(nm, ex, gt) \
  begin \
    compares++; \
    if ((gt) !== (ex)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module test_serial_register_access_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] MAKER = 16'h3c96; // Arbitrary maker code
  localparam int    NRD   = 10;
  logic         mclk, reset, chip_select_n, serial_clock, serial_in, serial_out, serial_out_oe_n;
  logic         cal_offset_we = 1'b0;
  logic [3:0]   cal_offset_sel = 4'h0;
  logic [7:0]   cal_offset_data = 8'h00;
  logic [7:0]   sync_pos = 8'hc5, osc_state = 8'h69, cal_state = 8'h3a;
  logic [127:0] core_offset_trim;
  logic [63:0]  core_fine_gain_trim;
  logic [15:0]  full_scale_adjust;
  logic         offset_cal_enable, background_cal_select;
  int           err_total = 0, compares = 0, cycles = 0;
  logic [14:0]  ra [NRD] = '{`SRAP_A_CFG_A, `SRAP_A_CLK0, `SRAP_A_CLK2, `SRAP_A_LP1, `SRAP_A_CALIBRATION_AVERAGING,
    `SRAP_A_LOW_POWER_BACKGROUND_CAL, `SRAP_A_LINK_EN, `SRAP_A_SYNC_POS, `SRAP_A_OSC_STATE, `SRAP_A_CAL_STATE};
  logic [7:0]   rv [NRD] = '{`SRAP_R_CFG_A, `SRAP_R_CLK0, `SRAP_R_CLK2, `SRAP_R_LP1, `SRAP_R_CALIBRATION_AVERAGING,
    `SRAP_R_LOW_POWER_BACKGROUND_CAL, `SRAP_R_LINK_EN, 8'hc5, 8'h69, 8'h3a};

  srap_port #(.MAKER_ID(MAKER)) u_dut (.mclk, .reset, .chip_select_n, .serial_clock, .serial_in,
    .serial_out, .serial_out_oe_n, .sync_capture_position(sync_pos), .oscillator_cal_state(osc_state),
    .calibration_state(cal_state), .cal_offset_we, .cal_offset_sel, .cal_offset_data, .core_offset_trim,
    .core_fine_gain_trim, .full_scale_adjust, .offset_cal_enable, .background_cal_select);
  srap_host_model u_host (.mclk, .chip_select_n, .serial_clock, .serial_in, .serial_out, .serial_out_oe_n);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic end_of_test();
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic wr(input logic [14:0] a, input int n, input logic [63:0] d, input int tail);
    logic [63:0] r;
    u_host.frame(1'b0, a, n, d, tail, r);
  endtask
  task automatic rd(input logic [14:0] a, input int n, output logic [63:0] r);
    u_host.frame(1'b1, a, n, 64'h0, 0, r);
  endtask
  // Only issued with the serial port idle
  task automatic cal_pulse(input logic [3:0] s, input logic [7:0] d);
    @(negedge mclk);
    cal_offset_sel = s;
    cal_offset_data = d;
    cal_offset_we = 1'b1;
    @(negedge mclk);
    cal_offset_we = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  initial begin
    logic [63:0] r;
    reset = 1'b1;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    `SRAP_CHK("full_scale", 16'ha000, full_scale_adjust)
    for (int i = 0; i < NRD; i++) begin
      rd(ra[i], 1, r);
      `SRAP_CHK("reset_read", rv[i], r[7:0])
    end
    rd(`SRAP_A_FS_LO, 2, r);
    `SRAP_CHK("fs_bytes", 16'ha000, r[15:0])
    rd(`SRAP_A_MAKER_LO, 2, r);
    `SRAP_CHK("maker", MAKER, r[15:0])
    wr(`SRAP_A_CLK1, 1, 64'h5c, 0);
    rd(`SRAP_A_CLK1, 1, r);
    `SRAP_CHK("write_back", 8'h5c, r[7:0])
    wr(`SRAP_A_CLK1, 0, 64'h1f, 5);
    rd(`SRAP_A_CLK1, 1, r);
    `SRAP_CHK("abort", 8'h5c, r[7:0])
    wr(`SRAP_A_GAIN_FIRST, 3, 64'h332211, 0);
    `SRAP_CHK("gain_up", 24'h332211, core_fine_gain_trim[23:0])
    rd(`SRAP_A_GAIN_FIRST, 3, r);
    `SRAP_CHK("stream_read", 24'h332211, r[23:0])
    wr(`SRAP_A_CFG_A, 1, 64'h10, 0);
    wr(`SRAP_A_GAIN_FIRST + 15'h0007, 2, 64'h6677, 0);
    `SRAP_CHK("gain_down", 16'h7766, core_fine_gain_trim[63:48])
    wr(`SRAP_A_CFG_A, 1, 64'h30, 0);
    wr(`SRAP_A_USR_CFG, 1, 64'h01, 0);
    wr(`SRAP_A_CLK1, 2, 64'h3cc3, 0);
    wr(`SRAP_A_USR_CFG, 1, 64'h00, 0);
    rd(`SRAP_A_CLK1, 2, r);
    `SRAP_CHK("hold", 16'h103c, r[15:0])
    wr(15'h0001, 1, 64'hff, 0);
    wr(`SRAP_A_SYNC_POS, 1, 64'hff, 0);
    rd(15'h0001, 2, r);
    `SRAP_CHK("reserved", 16'h0000, r[15:0])
    rd(`SRAP_A_SYNC_POS, 1, r);
    `SRAP_CHK("read_only", 8'hc5, r[7:0])
    wr(`SRAP_A_FS_LO, 2, 64'h1234, 0);
    `SRAP_CHK("fs_write", 16'h1234, full_scale_adjust)
    wr(`SRAP_A_OFS_FIRST + 15'h000e, 2, 64'hbeef, 0);
    `SRAP_CHK("ofs_serial", 16'hbeef, core_offset_trim[127:112])
    cal_pulse(4'h2, 8'h77);
    `SRAP_CHK("cal_off", 8'h00, core_offset_trim[23:16])
    wr(`SRAP_A_CALIBRATION_CONFIG_ZERO, 1, 64'h03, 0);
    `SRAP_CHK("cal_bits", 2'b11, {offset_cal_enable, background_cal_select})
    cal_pulse(4'h2, 8'h77);
    `SRAP_CHK("cal_on", 8'h77, core_offset_trim[23:16])
    `SRAP_CHK("gain_kept", 24'h332211, core_fine_gain_trim[23:0])
    end_of_test();
  end
endmodule // test_serial_register_access_port

bind srap_port srap_checker u_chk (.mclk, .reset, .chip_select_n, .serial_clock, .serial_in, .serial_out,
  .serial_out_oe_n, .cal_offset_we, .cal_offset_sel, .cal_offset_data, .core_offset_trim, .core_fine_gain_trim,
  .full_scale_adjust, .offset_cal_enable);
